// ===== logic/afe_config_space.sv
// Register space, profile memory and start-up control of the front end
`timescale 1ns/1ps
module afe_config_space import afe_pkg::*; #(
   parameter int WAKE_CYCLES = WAKE_CYC,
   parameter int ADC_DIV = ADC_DIV_DFLT
) (
   input wire logic clk_in,
   input wire logic reset_n_in,
   input wire logic sclk_in,
   input wire logic csb_n_in,
   input wire logic sdio_in,
   input wire logic transmit_trigger_in,
   output logic sdio_out,
   output logic sdio_oe_out,
   output logic power_down_out,
   output logic [1:0] speed_mode_out,
   output logic dcs_enable_out,
   output logic [NUM_CH*8-1:0] ch_gain_out,
   output logic bypass_demod_out,
   output logic bypass_rf_decim_out,
   output logic hpf_enable_out,
   output logic [1:0] digital_state_out,
   output logic [4:0] profile_index_out,
   output logic [4:0] decim_ratio_out,
   output logic [2:0] digital_gain_out,
   output logic filter_tuning_out,
   output logic coef_wr_out,
   output logic [11:0] coef_addr_out,
   output logic [7:0] coef_data_out
);
   if (WAKE_CYCLES < 1 || WAKE_CYCLES > 65535) begin : g_bad
      $error("afe_config_space: WAKE_CYCLES out of range");
   end

   typedef struct packed {
      logic [2:0] trig_sync;
      logic [7:0] port_cfg;
      logic [7:0] speed;
      logic [1:0] speed_act;
      logic speed_dirty;
      logic [7:0] chsel_lo;
      logic [7:0] chsel_hi;
      logic [7:0] power_mode;
      logic [7:0] gclk;
      logic [7:0] filt;
      logic [7:0] prof_idx;
      logic [7:0] dig_path;
      logic [7:0] chip_mode;
      logic [NUM_CH-1:0][7:0] gain;
      logic [PROF_BYTES-1:0][7:0] prof;
      logic [7:0][7:0] cur_prof;
      logic idx_pend;
      logic [15:0] wake_cnt;
      logic awake;
      afe_dig_t dig;
      logic [15:0] dig_cnt;
      logic tune_go;
      logic coef_wr;
      logic [11:0] coef_addr;
      logic [7:0] coef_data;
   } afe_state_t;

   // Defaults shared by the hard reset and the soft reset
   function automatic afe_state_t afe_defaults();
      afe_state_t d;
      d = '0;
      d.port_cfg = RST_PORT_CFG;
      d.speed = RST_SPEED;
      d.chsel_lo = RST_CHSEL_LO;
      d.chsel_hi = RST_CHSEL_HI;
      d.power_mode = RST_POWER_MODE;
      d.gclk = RST_GCLK;
      d.filt = RST_FILT;
      d.prof_idx = RST_PROF_IDX;
      d.dig_path = RST_DIG_PATH;
      d.chip_mode = RST_CHIP_MODE;
      d.gain = {NUM_CH{RST_GAIN}};
      d.dig = DIG_OFF;
      return d;
   endfunction : afe_defaults

   localparam afe_state_t RST_STATE = afe_defaults();

   afe_state_t r_reg, r_next;
   logic [12:0] addr;
   logic wr, wr_msb, tune_busy;
   logic [7:0] wdata, rd_data, gain_rd;
   logic [NUM_CH-1:0] ch_sel;
   logic wr_cfg, wr_prof, wr_coef, chip_ok, idx_wr, soft_trig, soft_rst;
   logic trig_rise, lsb_wr;
   logic [15:0] stop_cnt;
   logic [14:0] start_dly;

   ////////////////////////////////////////////////////////////////////////
   // Serial port and filter tuning timer
   afe_spi_port u_port (
      .clk_in(clk_in),
      .reset_n_in(reset_n_in),
      .sclk_in(sclk_in),
      .csb_n_in(csb_n_in),
      .sdio_in(sdio_in),
      .lsb_first_in(r_reg.port_cfg[PC_LSB_HI]),
      .rd_data_in(rd_data),
      .sdio_out(sdio_out),
      .sdio_oe_out(sdio_oe_out),
      .addr_out(addr),
      .wr_out(wr),
      .wr_data_out(wdata),
      .wr_msb_out(wr_msb)
   );

   afe_filter_tune #(
      .ADC_DIV(ADC_DIV),
      .TUNE_CYCLES(TUNE_ADC_CYC)
   ) u_tune (
      .clk_in(clk_in),
      .reset_n_in(reset_n_in),
      .start_in(r_reg.tune_go),
      .busy_out(tune_busy)
   );

   ////////////////////////////////////////////////////////////////////////
   // Address decode of the three regions
   assign wr_cfg = wr && (addr <= A_CFG_TOP);
   assign wr_prof = wr && (addr >= A_PROF_LO) && (addr <= A_PROF_HI);
   assign wr_coef = wr && (addr >= A_COEF_LO);
   assign chip_ok = !r_reg.chip_mode[CHIP_DESEL_BIT];
   assign ch_sel = {r_reg.chsel_hi[3:0], r_reg.chsel_lo[3:0]};
   assign idx_wr = wr_cfg && chip_ok && (addr == A_PROF_IDX);
   assign soft_trig = idx_wr && wdata[PIDX_TRIG_BIT];
   // Either mirrored reset bit starts a soft reset, e.g. 0x3C
   assign soft_rst = wr_cfg && (addr == A_PORT_CFG)
      && (wdata[PC_RST_HI] || wdata[PC_RST_LO]);
   assign lsb_wr = wdata[PC_LSB_HI] || wdata[PC_LSB_LO];
   // Transmit trigger edge taken after the second synchroniser flop
   assign trig_rise = r_reg.trig_sync[1] && !r_reg.trig_sync[2];
   assign stop_cnt = {r_reg.cur_prof[1], r_reg.cur_prof[0]};
   assign start_dly = {r_reg.cur_prof[3][6:0], r_reg.cur_prof[2]};

   ////////////////////////////////////////////////////////////////////////
   // Next-state logic: wake-up, digital block, register writes
   always_comb begin
      r_next = r_reg;
      r_next.coef_wr = 1'b0;
      r_next.tune_go = 1'b0;
      r_next.trig_sync = {r_reg.trig_sync[1:0], transmit_trigger_in};

      // Digital block sequencing in its own state
      case (r_reg.dig)
         DIG_OFF: begin
            if (r_reg.awake) begin
               r_next.dig = DIG_IDLE;
            end
         end
         DIG_IDLE: begin
            r_next.dig = DIG_IDLE;
         end
         DIG_DELAY: begin
            if (r_reg.dig_cnt == 16'd1) begin
               r_next.dig = DIG_RUN;
               r_next.dig_cnt = stop_cnt;
            end else begin
               r_next.dig_cnt = r_reg.dig_cnt - 16'd1;
            end
         end
         DIG_RUN: begin
            if (stop_cnt != STOP_FOREVER) begin
               if (r_reg.dig_cnt == 16'd0) begin
                  r_next.dig = DIG_IDLE;
               end else begin
                  r_next.dig_cnt = r_reg.dig_cnt - 16'd1;
               end
            end
         end
         default: begin
            r_next.dig = DIG_OFF;
         end
      endcase

      // A start wins over a return to idle in the same cycle
      if (r_reg.dig != DIG_OFF) begin
         if (soft_trig || (trig_rise && r_reg.dig == DIG_IDLE)) begin
            if (start_dly == 15'd0) begin
               r_next.dig = DIG_RUN;
               r_next.dig_cnt = stop_cnt;
            end else begin
               r_next.dig = DIG_DELAY;
               r_next.dig_cnt = {1'b0, start_dly};
            end
         end else if (trig_rise || idx_wr) begin
            r_next.dig = DIG_IDLE;
         end
      end

      // Wake-up timer; any power-down value holds the block off
      if (r_reg.power_mode != PWR_RUN) begin
         r_next.wake_cnt = 16'd0;
         r_next.awake = 1'b0;
         r_next.dig = DIG_OFF;
      end else if (!r_reg.awake) begin
         r_next.wake_cnt = r_reg.wake_cnt + 16'd1;
         if (r_reg.wake_cnt == 16'(WAKE_CYCLES - 1)) begin
            r_next.awake = 1'b1;
         end
      end

      // Registers that every write may reach
      if (wr_cfg) begin
         case (addr)
            A_PORT_CFG: begin
               r_next.port_cfg = RST_PORT_CFG;
               r_next.port_cfg[PC_LSB_HI] = lsb_wr;
               r_next.port_cfg[PC_LSB_LO] = lsb_wr;
            end
            A_CHSEL_LO: r_next.chsel_lo = wdata;
            A_CHSEL_HI: r_next.chsel_hi = wdata;
            A_CHIP_MODE: r_next.chip_mode = wdata;
            A_GAIN: begin
               for (int ch = 0; ch < NUM_CH; ch++) begin
                  if (ch_sel[ch]) begin
                     r_next.gain[ch] = wdata;
                  end
               end
            end
            default: r_next.chip_mode = r_reg.chip_mode;
         endcase
      end

      // Chip-wide registers, gated by the address mode
      if (wr_cfg && chip_ok) begin
         case (addr)
            A_SPEED: begin
               r_next.speed = wdata;
               r_next.speed_dirty = 1'b1;
            end
            A_UPDATE: begin
               if (r_reg.speed_dirty) begin
                  r_next.speed_act = r_reg.speed[SPD_LSB +: 2];
                  r_next.gain = {NUM_CH{RST_GAIN}};
                  r_next.speed_dirty = 1'b0;
               end
            end
            A_POWER_MODE: r_next.power_mode = wdata;
            A_GCLK: r_next.gclk = wdata;
            A_FILT: begin
               r_next.filt = wdata;
               r_next.tune_go = wdata[FILT_TUNE_BIT];
            end
            A_PROF_IDX: begin
               r_next.prof_idx = wdata;
               r_next.idx_pend = 1'b1;
            end
            A_DIG_PATH: r_next.dig_path = wdata;
            default: r_next.speed_dirty = r_reg.speed_dirty;
         endcase
      end

      // Profile buffer adopts the entry on the next MSB-first write
      if (wr && wr_msb && r_reg.idx_pend && !idx_wr) begin
         r_next.cur_prof = r_reg.prof[{r_reg.prof_idx[4:0], 3'b000} +: 8];
         r_next.idx_pend = 1'b0;
      end

      if (wr_prof) begin
         r_next.prof[addr[7:0]] = wdata;
      end

      // Coefficient bytes are handed on rather than stored here
      if (wr_coef) begin
         r_next.coef_wr = 1'b1;
         r_next.coef_addr = addr[11:0];
         r_next.coef_data = wdata;
      end

      // Soft reset leaves port config at its cleared default
      if (soft_rst) begin
         r_next = RST_STATE;
         r_next.trig_sync = {r_reg.trig_sync[1:0], transmit_trigger_in};
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Read data; local register shows the lowest selected channel
   always_comb begin
      rd_data = 8'h00;
      gain_rd = 8'h00;
      for (int ch = NUM_CH - 1; ch >= 0; ch--) begin
         if (ch_sel[ch]) begin
            gain_rd = r_reg.gain[ch];
         end
      end
      if (addr <= A_CFG_TOP) begin
         case (addr)
            A_PORT_CFG: rd_data = r_reg.port_cfg;
            A_SPEED: rd_data = r_reg.speed;
            A_CHSEL_LO: rd_data = r_reg.chsel_lo;
            A_CHSEL_HI: rd_data = r_reg.chsel_hi;
            A_POWER_MODE: rd_data = r_reg.power_mode;
            A_GCLK: rd_data = r_reg.gclk;
            A_GAIN: rd_data = gain_rd;
            A_FILT: rd_data = {r_reg.filt[7], tune_busy, r_reg.filt[5:0]};
            A_PROF_IDX: rd_data = r_reg.prof_idx;
            A_DIG_PATH: rd_data = r_reg.dig_path;
            A_CHIP_MODE: rd_data = r_reg.chip_mode;
            default: rd_data = 8'h00;
         endcase
      end else if (addr >= A_PROF_LO && addr <= A_PROF_HI) begin
         rd_data = r_reg.prof[addr[7:0]];
      end
   end

   // State register; asynchronous reset loads the defaults
   always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         r_reg <= RST_STATE;
      end else begin
         r_reg <= r_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Outputs
   assign power_down_out = !r_reg.awake;
   assign speed_mode_out = r_reg.speed_act;
   assign dcs_enable_out = r_reg.gclk[GCLK_DCS_BIT];
   assign ch_gain_out = r_reg.gain;
   assign bypass_demod_out = r_reg.dig_path[DP_BYP_DEMOD];
   assign bypass_rf_decim_out = r_reg.dig_path[DP_BYP_RF];
   // Profile bypass overrides the path enable
   assign hpf_enable_out = !r_reg.dig_path[DP_HPF_OFF]
      && !r_reg.cur_prof[3][START_HPF_BYP_BIT];
   assign digital_state_out = r_reg.dig;
   assign profile_index_out = r_reg.prof_idx[4:0];
   assign decim_ratio_out = r_reg.cur_prof[4][DECIM_LSB +: 5];
   assign digital_gain_out = r_reg.cur_prof[4][2:0];
   assign filter_tuning_out = tune_busy;
   assign coef_wr_out = r_reg.coef_wr;
   assign coef_addr_out = r_reg.coef_addr;
   assign coef_data_out = r_reg.coef_data;
endmodule : afe_config_space

// ===== inc/afe_pkg.sv
// Shared constants and types of the front-end configuration space
package afe_pkg;
   // Clock, wake-up and tuning timing, channel count and profile size
   localparam int CLK_MHZ = 125;
   localparam int WAKE_US = 375;
   localparam int WAKE_CYC = WAKE_US * CLK_MHZ;
   localparam int TUNE_ADC_CYC = 512;
   localparam int ADC_DIV_DFLT = 3;
   localparam int NUM_CH = 8;
   localparam int PROF_BYTES = 256;

   ////////////////////////////////////////////////////////////////////////
   // Address map (13-bit serial address)
   localparam logic [12:0] A_PORT_CFG = 13'h000;
   localparam logic [12:0] A_SPEED = 13'h002;
   localparam logic [12:0] A_CHSEL_LO = 13'h004;
   localparam logic [12:0] A_CHSEL_HI = 13'h005;
   localparam logic [12:0] A_POWER_MODE = 13'h008;
   localparam logic [12:0] A_GCLK = 13'h009;
   localparam logic [12:0] A_GAIN = 13'h011;
   localparam logic [12:0] A_FILT = 13'h02b;
   localparam logic [12:0] A_UPDATE = 13'h0ff;
   localparam logic [12:0] A_PROF_IDX = 13'h10c;
   localparam logic [12:0] A_DIG_PATH = 13'h113;
   localparam logic [12:0] A_CHIP_MODE = 13'h115;
   localparam logic [12:0] A_CFG_TOP = 13'h1a1;
   localparam logic [12:0] A_PROF_LO = 13'hf00;
   localparam logic [12:0] A_PROF_HI = 13'hfff;
   localparam logic [12:0] A_COEF_LO = 13'h1000;

   ////////////////////////////////////////////////////////////////////////
   // Values after reset, then the power-mode value PWR_RUN that runs the block
   localparam logic [7:0] RST_PORT_CFG = 8'h18;
   localparam logic [7:0] RST_SPEED = 8'h00;
   localparam logic [7:0] RST_CHSEL_LO = 8'h0f;
   localparam logic [7:0] RST_CHSEL_HI = 8'h0f;
   localparam logic [7:0] RST_POWER_MODE = 8'h01;
   localparam logic [7:0] RST_GCLK = 8'h01;
   localparam logic [7:0] RST_GAIN = 8'h06;
   localparam logic [7:0] RST_FILT = 8'h00;
   localparam logic [7:0] RST_PROF_IDX = 8'h00;
   localparam logic [7:0] RST_DIG_PATH = 8'h00;
   localparam logic [7:0] RST_CHIP_MODE = 8'h00;
   localparam logic [7:0] PWR_RUN = 8'h00;

   ////////////////////////////////////////////////////////////////////////
   // Field positions, and the stop count that means run forever
   localparam int PC_LSB_HI = 6;
   localparam int PC_RST_HI = 5;
   localparam int PC_RST_LO = 2;
   localparam int PC_LSB_LO = 1;
   localparam int SPD_LSB = 4;
   localparam int CHIP_DESEL_BIT = 0;
   localparam int PIDX_TRIG_BIT = 5;
   localparam int DP_BYP_DEMOD = 0;
   localparam int DP_BYP_RF = 1;
   localparam int DP_HPF_OFF = 2;
   localparam int FILT_TUNE_BIT = 6;
   localparam int GCLK_DCS_BIT = 0;
   localparam int START_HPF_BYP_BIT = 7;
   localparam int DECIM_LSB = 3;
   localparam logic [15:0] STOP_FOREVER = 16'h7fff;

   // Digital block states
   typedef enum logic [1:0] {
      DIG_OFF = 2'b00,
      DIG_IDLE = 2'b01,
      DIG_DELAY = 2'b10,
      DIG_RUN = 2'b11
   } afe_dig_t;
endpackage : afe_pkg

// ===== logic/afe_spi_port.sv
// Three-wire serial register port, oversampled on the system clock
`timescale 1ns/1ps
module afe_spi_port import afe_pkg::*; (
   input wire logic clk_in,
   input wire logic reset_n_in,
   input wire logic sclk_in,
   input wire logic csb_n_in,
   input wire logic sdio_in,
   input wire logic lsb_first_in,
   input wire logic [7:0] rd_data_in,
   output logic sdio_out,
   output logic sdio_oe_out,
   output logic [12:0] addr_out,
   output logic wr_out,
   output logic [7:0] wr_data_out,
   output logic wr_msb_out
);
   typedef struct packed {
      logic [2:0] sclk_s;
      logic [1:0] csb_s;
      logic [1:0] sd_s;
      logic [15:0] sh;
      logic [3:0] cnt;
      logic instr;
      logic rd;
      logic [1:0] w;
      logic [1:0] nbytes;
      logic [12:0] addr;
      logic [7:0] osh;
      logic sdo;
      logic oe;
      logic wr;
      logic [7:0] wdata;
      logic wmsb;
   } afe_spi_t;

   afe_spi_t r_reg, r_next;
   logic rise, fall, last_byte;
   logic [7:0] byte_in, byte_out;

   function automatic logic [7:0] rev8(input logic [7:0] x);
      logic [7:0] y;
      for (int i = 0; i < 8; i++) begin
         y[i] = x[7 - i];
      end
      return y;
   endfunction : rev8

   ////////////////////////////////////////////////////////////////////////
   // Edges of the second synchroniser stage only
   assign rise = r_reg.sclk_s[1] & ~r_reg.sclk_s[2] & ~r_reg.csb_s[1];
   assign fall = ~r_reg.sclk_s[1] & r_reg.sclk_s[2] & ~r_reg.csb_s[1];
   assign byte_in = {r_reg.sh[6:0], r_reg.sd_s[1]};
   assign byte_out = lsb_first_in ? rev8(rd_data_in) : rd_data_in;
   assign last_byte = (r_reg.w != 2'b11) && (r_reg.nbytes == r_reg.w);

   // Instruction then data bytes; chip select high drops the frame
   always_comb begin
      r_next = r_reg;
      r_next.wr = 1'b0;
      // Step past a written byte only once its strobe has gone out
      if (r_reg.wr) begin
         r_next.addr = r_reg.addr + 13'd1;
      end
      r_next.sclk_s = {r_reg.sclk_s[1:0], sclk_in};
      r_next.csb_s = {r_reg.csb_s[0], csb_n_in};
      r_next.sd_s = {r_reg.sd_s[0], sdio_in};
      if (r_reg.csb_s[1]) begin
         r_next.cnt = '0;
         r_next.instr = 1'b0;
         r_next.oe = 1'b0;
      end else if (rise && !r_reg.instr) begin
         r_next.sh = {r_reg.sh[14:0], r_reg.sd_s[1]};
         r_next.cnt = r_reg.cnt + 4'd1;
         if (r_reg.cnt == 4'd15) begin
            r_next.instr = 1'b1;
            r_next.rd = r_reg.sh[14];
            r_next.w = r_reg.sh[13:12];
            r_next.addr = {r_reg.sh[11:0], r_reg.sd_s[1]};
            r_next.nbytes = 2'd0;
         end
      end else if (rise) begin
         r_next.sh = {r_reg.sh[14:0], r_reg.sd_s[1]};
         r_next.cnt = {1'b0, r_reg.cnt[2:0] + 3'd1};
         if (r_reg.cnt[2:0] == 3'd7) begin
            // A write keeps its address for the strobe cycle
            if (r_reg.rd) begin
               r_next.addr = r_reg.addr + 13'd1;
            end
            r_next.nbytes = r_reg.nbytes + 2'd1;
            r_next.instr = !last_byte;
            r_next.cnt = 4'd0;
            if (last_byte) begin
               r_next.oe = 1'b0;
            end
            if (!r_reg.rd) begin
               r_next.wr = 1'b1;
               r_next.wdata = lsb_first_in ? rev8(byte_in) : byte_in;
               r_next.wmsb = !lsb_first_in;
            end
         end
      end else if (fall && r_reg.instr && r_reg.rd) begin
         r_next.oe = 1'b1;
         if (r_reg.cnt[2:0] == 3'd0) begin
            r_next.sdo = byte_out[7];
            r_next.osh = {byte_out[6:0], 1'b0};
         end else begin
            r_next.sdo = r_reg.osh[7];
            r_next.osh = {r_reg.osh[6:0], 1'b0};
         end
      end
   end

   // State register
   always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         r_reg <= '0;
      end else begin
         r_reg <= r_next;
      end
   end

   assign sdio_out = r_reg.sdo;
   assign sdio_oe_out = r_reg.oe;
   assign addr_out = r_reg.addr;
   assign wr_out = r_reg.wr;
   assign wr_data_out = r_reg.wdata;
   assign wr_msb_out = r_reg.wmsb;
endmodule : afe_spi_port

// ===== logic/afe_filter_tune.sv
// Analog filter tuning timer counted in sample-clock ticks
`timescale 1ns/1ps
module afe_filter_tune import afe_pkg::*; #(
   parameter int ADC_DIV = ADC_DIV_DFLT,
   parameter int TUNE_CYCLES = TUNE_ADC_CYC
) (
   input wire logic clk_in,
   input wire logic reset_n_in,
   input wire logic start_in,
   output logic busy_out
);
   if (ADC_DIV < 1 || ADC_DIV > 256 || TUNE_CYCLES < 1
       || TUNE_CYCLES > 1024) begin : g_bad
      $error("afe_filter_tune: unsupported parameter value");
   end

   typedef struct packed {
      logic [7:0] div;
      logic [9:0] cnt;
      logic busy;
   } afe_tune_t;

   afe_tune_t r_reg, r_next;
   logic tick;

   ////////////////////////////////////////////////////////////////////////
   // Sample-clock enable from a divider of the system clock
   assign tick = (r_reg.div == 8'(ADC_DIV - 1));

   // A new request restarts the full count
   always_comb begin
      r_next = r_reg;
      r_next.div = tick ? 8'd0 : r_reg.div + 8'd1;
      if (start_in) begin
         r_next.busy = 1'b1;
         r_next.cnt = '0;
      end else if (r_reg.busy && tick) begin
         r_next.cnt = r_reg.cnt + 10'd1;
         if (r_reg.cnt == 10'(TUNE_CYCLES - 1)) begin
            r_next.busy = 1'b0;
         end
      end
   end

   // State register
   always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         r_reg <= '0;
      end else begin
         r_reg <= r_next;
      end
   end

   assign busy_out = r_reg.busy;
endmodule : afe_filter_tune

// ===== dv/afe_host.sv
// Host model that issues one-byte serial register writes
`timescale 1ns/1ps
module afe_host (
   input logic clk_in,
   input logic sdo_in,
   input logic sdo_oe_in,
   output logic sclk_out,
   output logic csb_n_out,
   output logic sdio_out
);
   logic rd_mode = 1'b0;
   logic [7:0] rd_byte;
   // Clock starts low and select high; after a frame the clock is left high
   initial {sclk_out, csb_n_out, sdio_out} = 3'b010;
   // Six clocks a phase leave the port synchronisers room to spare
   task automatic wr(input logic [12:0] addr, input logic [7:0] data);
      logic [23:0] frame;
      frame = {rd_mode, 2'b00, addr, data};
      @(posedge clk_in) csb_n_out <= 1'b0;
      for (int i = 23; i >= 0; i--) begin
         @(posedge clk_in) sclk_out <= 1'b0;
         sdio_out <= frame[i];
         repeat (6) @(posedge clk_in);
         sclk_out <= 1'b1;
         // An undriven bit reads as one so a missing enable shows
         if (i < 8) rd_byte[i] = sdo_in | !sdo_oe_in;
         repeat (6) @(posedge clk_in);
      end
      {csb_n_out, sdio_out} <= {1'b1, ~frame[0]};
      repeat (12) @(negedge clk_in);
   endtask : wr
   // Read frame: the device shifts a bit out on each fall
   task automatic rd(input logic [12:0] addr);
      rd_mode = 1'b1;
      wr(addr, 8'h00);
      rd_mode = 1'b0;
   endtask : rd
endmodule : afe_host

// ===== dv/afe_config_space_chk.sv
// Port assertions of the front-end configuration space
`timescale 1ns/1ps
module afe_config_space_chk import afe_pkg::*; #(
   parameter int ADC_DIV = ADC_DIV_DFLT
) (
   input logic clk_in,
   input logic reset_n_in,
   input logic transmit_trigger_in,
   input logic power_down_out,
   input logic [1:0] digital_state_out,
   input logic filter_tuning_out,
   input logic coef_wr_out,
   input logic [11:0] coef_addr_out
);
   localparam int TUNE = TUNE_ADC_CYC * ADC_DIV;
   int tn_reg;
   default clocking @(posedge clk_in); endclocking
   default disable iff (!reset_n_in);
   // Length of the running tuning pulse, so a stuck flag is caught
   always_ff @(posedge clk_in or negedge reset_n_in)
      if (!reset_n_in) tn_reg <= 0;
      else tn_reg <= filter_tuning_out ? tn_reg + 1 : 0;
   sequence s_trig; $rose(transmit_trigger_in); endsequence
   property p_rst; $rose(reset_n_in) |-> power_down_out; endproperty
   property p_off; power_down_out |-> digital_state_out == 2'b00; endproperty
   property p_go;
      digital_state_out == 2'b01 ##0 s_trig |-> ##[1:6] digital_state_out[1];
   endproperty
   property p_stop;
      digital_state_out[1] ##0 s_trig |-> ##[1:6] digital_state_out == 2'b01;
   endproperty
   property p_tmax; filter_tuning_out |-> tn_reg < TUNE + 1; endproperty
   property p_tlen;
      $fell(filter_tuning_out) |-> tn_reg > TUNE - ADC_DIV - 2;
   endproperty
   property p_cw; coef_wr_out |=> !coef_wr_out; endproperty
   property p_ca; coef_wr_out |=> $stable(coef_addr_out) [*4]; endproperty
   a_rst: assert property (p_rst) else $error("awake after reset");
   a_off: assert property (p_off) else $error("runs while down");
   a_go: assert property (p_go) else $error("trigger no start");
   a_stop: assert property (p_stop) else $error("trigger no idle");
   a_tmax: assert property (p_tmax) else $error("tuning too long");
   a_tlen: assert property (p_tlen) else $error("tuning too short");
   a_cw: assert property (p_cw) else $error("coef pulse long");
   a_ca: assert property (p_ca) else $error("coef addr moved");
endmodule : afe_config_space_chk
bind afe_config_space afe_config_space_chk #(.ADC_DIV(ADC_DIV)) u_chk (.*);

// ===== dv/afe_config_space_test.sv
// Start-up sequence bench for the front-end register space
`timescale 1ns/1ps
module afe_config_space_test import afe_pkg::*;;
   logic clk_in, reset_n_in, sclk_in, csb_n_in, sdio_in, sdio_out;
   logic sdio_oe_out, power_down_out, dcs_enable_out, bypass_demod_out;
   logic bypass_rf_decim_out, hpf_enable_out, filter_tuning_out;
   logic coef_wr_out, transmit_trigger_in;
   logic [1:0] speed_mode_out, digital_state_out;
   logic [63:0] ch_gain_out;
   logic [4:0] profile_index_out, decim_ratio_out;
   logic [2:0] digital_gain_out;
   logic [11:0] coef_addr_out;
   logic [7:0] coef_data_out;
   int error_cnt = 0, comparisons = 0, cycles = 0;
   afe_config_space #(.WAKE_CYCLES(20), .ADC_DIV(1)) dut (.*);
   afe_host host (.clk_in(clk_in), .sdo_in(sdio_out),
      .sdo_oe_in(sdio_oe_out), .sclk_out(sclk_in),
      .csb_n_out(csb_n_in), .sdio_out(sdio_in));
   task automatic chk(input logic [11:0] got, input logic [11:0] exp);
      comparisons++;
      if (got !== exp) begin
         error_cnt++;
         $display("[ERR] %0t got %h want %h", $time, got, exp);
      end
   endtask : chk
   task automatic complete_run;
      if (error_cnt == 0 && comparisons > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : complete_run
   task automatic t_rst;
      chk({power_down_out, dcs_enable_out, digital_state_out,
         ch_gain_out[55:48]}, 12'hc06);
   endtask : t_rst
   task automatic t_boot;
      logic [7:0] prof [8] = '{8'hff, 8'h7f, 8'h00, 8'h80, 8'h0c, 8'h00,
         8'h00, 8'h20};
      host.wr(A_PORT_CFG, 8'h3c);
      host.wr(A_SPEED, 8'h30);
      chk(speed_mode_out, 12'h0);
      host.wr(A_UPDATE, 8'h01);
      chk(speed_mode_out, 12'h3);
      foreach (prof[i]) host.wr(A_PROF_LO + 13'(i), prof[i]);
      host.wr(A_PROF_IDX, 8'h00);
      chk(decim_ratio_out, 12'h0);
      host.wr(A_DIG_PATH, 8'h03);
      chk({bypass_demod_out, bypass_rf_decim_out, hpf_enable_out,
         decim_ratio_out, digital_gain_out}, 12'h60c);
   endtask : t_boot
   task automatic t_run;
      host.wr(A_POWER_MODE, PWR_RUN);
      repeat (30) @(negedge clk_in);
      chk(digital_state_out, 12'h1);
      host.wr(A_PROF_IDX, 8'h20);
      chk(digital_state_out, 12'h3);
      // Hardware trigger stops the running block, then restarts it
      for (int n = 0; n < 2; n++) begin
         @(posedge clk_in) transmit_trigger_in <= 1'b1;
         repeat (8) @(posedge clk_in);
         transmit_trigger_in <= 1'b0;
         repeat (8) @(negedge clk_in);
         chk(digital_state_out, n ? 12'h3 : 12'h1);
      end
   endtask : t_run
   task automatic t_sel;
      host.wr(A_CHIP_MODE, 8'h01);
      host.wr(A_DIG_PATH, 8'h00);
      host.wr(A_CHIP_MODE, 8'h00);
      host.wr(A_CHSEL_LO, 8'h01);
      host.wr(A_CHSEL_HI, 8'h00);
      host.wr(A_GAIN, 8'h0a);
      chk({bypass_demod_out, ch_gain_out[10:0]}, 12'he0a);
      host.rd(A_GAIN);
      chk(host.rd_byte, 12'h00a);
      host.wr(A_COEF_LO + 13'h005, 8'h5a);
      chk(coef_addr_out ^ {4'h0, coef_data_out}, 12'h05f);
   endtask : t_sel
   task automatic t_end;
      host.wr(A_FILT, 8'h40);
      chk(filter_tuning_out, 12'h1);
      host.rd(A_FILT);
      chk(host.rd_byte, 12'h040);
      repeat (520) @(negedge clk_in);
      chk(filter_tuning_out, 12'h0);
      host.wr(A_PORT_CFG, 8'h3c);
      chk({power_down_out, bypass_demod_out, ch_gain_out[7:0]}, 12'h206);
   endtask : t_end
   // Clock, hang guard well above the nine thousand cycles planned
   initial begin
      clk_in = 1'b0;
      forever #4 clk_in = ~clk_in;
   end
   always @(posedge clk_in) begin
      cycles++;
      if (cycles == 20000) begin
         error_cnt++;
         complete_run();
      end
   end
   // Reset, the scenarios in start-up order, verdict
   initial begin
      reset_n_in = 1'b0;
      transmit_trigger_in = 1'b0;
      repeat (8) @(posedge clk_in);
      reset_n_in <= 1'b1;
      repeat (4) @(negedge clk_in);
      t_rst();
      t_boot();
      t_run();
      t_sel();
      t_end();
      complete_run();
   end
endmodule : afe_config_space_test
